// File: coproc_xfer_pkg.sv
// Purpose: Shared constants for the coprocessor register transfer block
// Assumes: 32-bit instruction words, flags ordered negative, zero, carry, overflow
// Notes: Operation list below
//
// Operation
// - Execute only when the condition field evaluates true, else no effect; mem_offset_ff is still loaded for the memory class when the condition fails
// - Transfer class is bits 27:24 equal 1110 with bit 4 set
// - Fields: cond, opcode, primary reg, core reg, number, info, second reg
// - Bit 20 low moves core to coprocessor, high moves coprocessor to core
// - Coprocessor number field selects which attached coprocessor responds
// - Opcode, info and both coprocessor register fields pass through uninterpreted
// - Coprocessor to core with program counter destination loads word 31:28 into flags
// - Flag transfer discards other bits, program counter and other status untouched
// - Core to coprocessor with program counter source sends instruction address plus 12
// - Coprocessor to core takes 1 S, busy count plus one I, 1 C
// - Core to coprocessor takes 1 S, busy count I cycles, 1 C
// - Memory transfer offset field counts words, scaled by four to bytes
// - Undefined class with true condition traps after offering to coprocessors
// - Undefined class handling takes 2 S, 1 I and 1 N cycles
package coproc_xfer_pkg;
  localparam int unsigned COND_HI = 31;
  localparam int unsigned COND_LO = 28;
  localparam int unsigned CLASS_HI = 27;
  localparam int unsigned CLASS_LO = 24;
  localparam logic [3:0] XFER_CLASS = 4'he;
  localparam int unsigned MARK_BIT = 4;
  localparam logic [2:0] UNDEF_CLASS = 3'h3;
  localparam logic [2:0] MEM_CLASS = 3'h6;
  localparam int unsigned OPC_HI = 23;
  localparam int unsigned OPC_LO = 21;
  localparam int unsigned DIR_BIT = 20;
  localparam int unsigned PRIM_HI = 19;
  localparam int unsigned PRIM_LO = 16;
  localparam int unsigned CORE_HI = 15;
  localparam int unsigned CORE_LO = 12;
  localparam int unsigned NUM_HI = 11;
  localparam int unsigned NUM_LO = 8;
  localparam int unsigned INFO_HI = 7;
  localparam int unsigned INFO_LO = 5;
  localparam int unsigned SEC_HI = 3;
  localparam int unsigned SEC_LO = 0;
  localparam int unsigned OFS_HI = 7;
  localparam logic [3:0] PC_INDEX = 4'hf;
  localparam logic [31:0] PC_AHEAD = 32'h0000000c;
  localparam logic [31:0] WORD_RST = 32'h00000000;
  localparam logic [15:0] BUSY_CNT_RST = 16'h0000;
  localparam logic [2:0] CYC_NONE = 3'h0;
  localparam logic [2:0] CYC_SEQ = 3'h1;
  localparam logic [2:0] CYC_NONSEQ = 3'h2;
  localparam logic [2:0] CYC_INT = 3'h3;
  localparam logic [2:0] CYC_COPROC = 3'h4;
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_OFFER = 3'h1,
    ST_WAIT = 3'h3,
    ST_EXTRA = 3'h2,
    ST_XFER = 3'h6,
    ST_UND_S = 3'h7,
    ST_UND_I = 3'h5,
    ST_UND_N = 3'h4
  } xfer_state_e;
endpackage : coproc_xfer_pkg

// File: cond_check.sv
// Purpose: Evaluates a four-bit condition field against the flags
// Assumes: flags are negative, zero, carry, overflow from bit 3 down
// Notes: Code 1111 never passes
`timescale 1ns/1ps
module cond_check (
  input wire logic [3:0] cond,
  input wire logic [3:0] flags,
  output logic pass
);
  logic n;
  logic z;
  logic c;
  logic v;
  assign n = flags[3];
  assign z = flags[2];
  assign c = flags[1];
  assign v = flags[0];

  always_comb begin
    case (cond)
      4'h0: pass = z;
      4'h1: pass = !z;
      4'h2: pass = c;
      4'h3: pass = !c;
      4'h4: pass = n;
      4'h5: pass = !n;
      4'h6: pass = v;
      4'h7: pass = !v;
      4'h8: pass = c && !z;
      4'h9: pass = !c || z;
      4'ha: pass = n == v;
      4'hb: pass = n != v;
      4'hc: pass = !z && (n == v);
      4'hd: pass = z || (n != v);
      4'he: pass = 1'b1;
      default: pass = 1'b0;
    endcase
  end
endmodule : cond_check

// File: coproc_register_transfer.sv
// Purpose: Core-side sequencer for coprocessor register transfers and undefined trap
// Assumes: Inputs synchronous to sys_clk; one instruction in flight at a time
// Notes: Handshake sampled in the offer and wait cycles
`timescale 1ns/1ps
module coproc_register_transfer
  import coproc_xfer_pkg::*;
(
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic clk_en,
  input wire logic instr_valid,
  input wire logic [31:0] instr,
  input wire logic [31:0] instr_addr,
  input wire logic [31:0] core_rdata,
  input wire logic [3:0] flags_in,
  input wire logic coproc_absent_signal,
  input wire logic coproc_wait_signal,
  input wire logic [31:0] coproc_rdata,
  output logic busy_ff,
  output logic done_ff,
  output logic offer_ff,
  output logic dir_load_ff,
  output logic [3:0] coproc_number_field_ff,
  output logic [2:0] coproc_opcode_field_ff,
  output logic [2:0] coproc_info_field_ff,
  output logic [3:0] coproc_primary_register_ff,
  output logic [3:0] coproc_second_operand_reg_ff,
  output logic [31:0] coproc_wdata_ff,
  output logic coproc_wdata_valid_ff,
  output logic reg_we_ff,
  output logic [3:0] reg_idx_ff,
  output logic [31:0] reg_wdata_ff,
  output logic flag_we_ff,
  output logic [3:0] flag_data_ff,
  output logic undef_trap_ff,
  output logic [2:0] cycle_kind_ff,
  output logic [15:0] busy_count_ff,
  output logic [9:0] mem_offset_ff
);
  ////////////////////////////////////////////////////////////////////////
  // Decode
  xfer_state_e state_ff, nxt_state;
  logic cond_pass;
  logic is_xfer;
  logic is_undef;
  logic is_mem;
  logic load_now;

  cond_check u_cond (
    .cond(instr[COND_HI:COND_LO]),
    .flags(flags_in),
    .pass(cond_pass)
  );

  assign is_xfer = (instr[CLASS_HI:CLASS_LO] == XFER_CLASS) && instr[MARK_BIT];
  assign is_undef = (instr[CLASS_HI:CLASS_LO+1] == UNDEF_CLASS) && instr[MARK_BIT];
  assign is_mem = instr[CLASS_HI:CLASS_LO+1] == MEM_CLASS;
  assign load_now = instr[DIR_BIT];

  ////////////////////////////////////////////////////////////////////////
  // Next state and outputs
  logic nxt_busy, nxt_done, nxt_offer, nxt_dir_load, nxt_wvalid, nxt_reg_we, nxt_flag_we, nxt_trap, nxt_undef_kind;
  logic undef_kind_ff;
  logic [3:0] nxt_num, nxt_prim, nxt_sec, nxt_reg_idx, nxt_flag_data;
  logic [2:0] nxt_opc, nxt_info, nxt_cycle;
  logic [31:0] nxt_wdata, nxt_reg_wdata;
  logic [15:0] nxt_busy_count;
  logic [9:0] nxt_mem_offset;

  always_comb begin
    nxt_state = state_ff;
    nxt_busy = busy_ff;
    nxt_done = 1'b0;
    nxt_offer = offer_ff;
    nxt_dir_load = dir_load_ff;
    nxt_num = coproc_number_field_ff;
    nxt_opc = coproc_opcode_field_ff;
    nxt_info = coproc_info_field_ff;
    nxt_prim = coproc_primary_register_ff;
    nxt_sec = coproc_second_operand_reg_ff;
    nxt_wdata = coproc_wdata_ff;
    nxt_wvalid = 1'b0;
    nxt_reg_we = 1'b0;
    nxt_reg_idx = reg_idx_ff;
    nxt_reg_wdata = reg_wdata_ff;
    nxt_flag_we = 1'b0;
    nxt_flag_data = flag_data_ff;
    nxt_trap = 1'b0;
    nxt_undef_kind = undef_kind_ff;
    nxt_busy_count = busy_count_ff;
    nxt_mem_offset = mem_offset_ff;
    case (state_ff)
      ST_IDLE: begin
        if (instr_valid) begin
          if (is_mem) begin
            nxt_mem_offset = {instr[OFS_HI:0], 2'b00};
          end
          if (cond_pass && (is_xfer || is_undef)) begin
            nxt_state = ST_OFFER;
            nxt_busy = 1'b1;
            nxt_offer = 1'b1;
            nxt_undef_kind = is_undef;
            nxt_dir_load = load_now;
            nxt_num = instr[NUM_HI:NUM_LO];
            nxt_opc = instr[OPC_HI:OPC_LO];
            nxt_info = instr[INFO_HI:INFO_LO];
            nxt_prim = instr[PRIM_HI:PRIM_LO];
            nxt_sec = instr[SEC_HI:SEC_LO];
            nxt_reg_idx = instr[CORE_HI:CORE_LO];
            nxt_busy_count = BUSY_CNT_RST;
            if (instr[CORE_HI:CORE_LO] == PC_INDEX) begin
              nxt_wdata = instr_addr + PC_AHEAD;
            end else begin
              nxt_wdata = core_rdata;
            end
          end else begin
            nxt_done = 1'b1;
          end
        end
      end
      ST_OFFER: begin
        if (undef_kind_ff || coproc_absent_signal) begin
          nxt_state = ST_UND_S;
          nxt_offer = 1'b0;
        end else if (coproc_wait_signal) begin
          nxt_state = ST_WAIT;
        end else begin
          nxt_state = dir_load_ff ? ST_EXTRA : ST_XFER;
          nxt_offer = 1'b0;
        end
      end
      ST_WAIT: begin
        nxt_busy_count = busy_count_ff + 16'h0001;
        if (coproc_absent_signal) begin
          nxt_state = ST_UND_S;
          nxt_offer = 1'b0;
        end else if (!coproc_wait_signal) begin
          nxt_state = dir_load_ff ? ST_EXTRA : ST_XFER;
          nxt_offer = 1'b0;
        end
      end
      ST_EXTRA: begin
        nxt_state = ST_XFER;
      end
      ST_XFER: begin
        nxt_state = ST_IDLE;
        nxt_busy = 1'b0;
        nxt_done = 1'b1;
        if (!dir_load_ff) begin
          nxt_wvalid = 1'b1;
        end else if (reg_idx_ff == PC_INDEX) begin
          nxt_flag_we = 1'b1;
          nxt_flag_data = coproc_rdata[31:28];
        end else begin
          nxt_reg_we = 1'b1;
          nxt_reg_wdata = coproc_rdata;
        end
      end
      ST_UND_S: begin
        nxt_state = ST_UND_I;
      end
      ST_UND_I: begin
        nxt_state = ST_UND_N;
      end
      ST_UND_N: begin
        nxt_state = ST_IDLE;
        nxt_busy = 1'b0;
        nxt_done = 1'b1;
        nxt_trap = 1'b1;
      end
      default: begin
        nxt_state = ST_IDLE;
        nxt_busy = 1'b0;
        nxt_offer = 1'b0;
      end
    endcase
    case (nxt_state)
      ST_OFFER, ST_UND_S: nxt_cycle = CYC_SEQ;
      ST_WAIT, ST_EXTRA, ST_UND_I: nxt_cycle = CYC_INT;
      ST_XFER: nxt_cycle = CYC_COPROC;
      ST_UND_N: nxt_cycle = CYC_NONSEQ;
      default: nxt_cycle = CYC_NONE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Registers
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state_ff <= ST_IDLE;
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
      offer_ff <= 1'b0;
      dir_load_ff <= 1'b0;
      undef_kind_ff <= 1'b0;
      coproc_number_field_ff <= 4'h0;
      coproc_opcode_field_ff <= 3'h0;
      coproc_info_field_ff <= 3'h0;
      coproc_primary_register_ff <= 4'h0;
      coproc_second_operand_reg_ff <= 4'h0;
      coproc_wdata_ff <= WORD_RST;
      coproc_wdata_valid_ff <= 1'b0;
      reg_we_ff <= 1'b0;
      reg_idx_ff <= 4'h0;
      reg_wdata_ff <= WORD_RST;
      flag_we_ff <= 1'b0;
      flag_data_ff <= 4'h0;
      undef_trap_ff <= 1'b0;
      cycle_kind_ff <= CYC_NONE;
      busy_count_ff <= BUSY_CNT_RST;
      mem_offset_ff <= 10'h000;
    end else if (clk_en) begin
      state_ff <= nxt_state;
      busy_ff <= nxt_busy;
      done_ff <= nxt_done;
      offer_ff <= nxt_offer;
      dir_load_ff <= nxt_dir_load;
      undef_kind_ff <= nxt_undef_kind;
      coproc_number_field_ff <= nxt_num;
      coproc_opcode_field_ff <= nxt_opc;
      coproc_info_field_ff <= nxt_info;
      coproc_primary_register_ff <= nxt_prim;
      coproc_second_operand_reg_ff <= nxt_sec;
      coproc_wdata_ff <= nxt_wdata;
      coproc_wdata_valid_ff <= nxt_wvalid;
      reg_we_ff <= nxt_reg_we;
      reg_idx_ff <= nxt_reg_idx;
      reg_wdata_ff <= nxt_reg_wdata;
      flag_we_ff <= nxt_flag_we;
      flag_data_ff <= nxt_flag_data;
      undef_trap_ff <= nxt_trap;
      cycle_kind_ff <= nxt_cycle;
      busy_count_ff <= nxt_busy_count;
      mem_offset_ff <= nxt_mem_offset;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge sys_clk iff clk_en); endclocking
  default disable iff (!resetn);

  property p_cond_skip;
    state_ff == ST_IDLE && instr_valid && !cond_pass |=> done_ff && !busy_ff && !reg_we_ff && !undef_trap_ff;
  endproperty
  a_cond_skip: assert property (p_cond_skip) else $error("failed condition still acted");

  property p_decode;
    state_ff == ST_IDLE && instr_valid && cond_pass && is_xfer |=> state_ff == ST_OFFER && offer_ff;
  endproperty
  a_decode: assert property (p_decode) else $error("transfer not recognised");

  property p_fields;
    state_ff == ST_IDLE && instr_valid && cond_pass && is_xfer |=> coproc_number_field_ff == $past(instr[11:8])
      && coproc_primary_register_ff == $past(instr[19:16]) && coproc_second_operand_reg_ff == $past(instr[3:0]);
  endproperty
  a_fields: assert property (p_fields) else $error("field passed wrongly");

  property p_flags;
    state_ff == ST_XFER && dir_load_ff && reg_idx_ff == PC_INDEX |=> flag_we_ff && !reg_we_ff
      && flag_data_ff == $past(coproc_rdata[31:28]);
  endproperty
  a_flags: assert property (p_flags) else $error("flag transfer wrong");

  property p_pc_ahead;
    state_ff == ST_IDLE && instr_valid && cond_pass && is_xfer && !load_now && instr[15:12] == 4'hf
      |=> coproc_wdata_ff == $past(instr_addr) + 32'h0000000c;
  endproperty
  a_pc_ahead: assert property (p_pc_ahead) else $error("pc source word wrong");

  property p_load_timing;
    state_ff == ST_WAIT && dir_load_ff && !coproc_wait_signal && !coproc_absent_signal
      |=> cycle_kind_ff == CYC_INT ##1 cycle_kind_ff == CYC_COPROC ##1 reg_we_ff || flag_we_ff;
  endproperty
  a_load_timing: assert property (p_load_timing) else $error("load cycle count wrong");

  property p_store_timing;
    state_ff == ST_WAIT && !dir_load_ff && !coproc_wait_signal && !coproc_absent_signal
      |=> cycle_kind_ff == CYC_COPROC ##1 coproc_wdata_valid_ff && done_ff;
  endproperty
  a_store_timing: assert property (p_store_timing) else $error("store cycle count wrong");

  property p_offset;
    state_ff == ST_IDLE && instr_valid && is_mem |=> mem_offset_ff == {$past(instr[7:0]), 2'b00};
  endproperty
  a_offset: assert property (p_offset) else $error("offset not scaled");

  property p_undef;
    state_ff == ST_OFFER && undef_kind_ff |=> cycle_kind_ff == CYC_SEQ ##1 cycle_kind_ff == CYC_INT
      ##1 cycle_kind_ff == CYC_NONSEQ ##1 undef_trap_ff && done_ff;
  endproperty
  a_undef: assert property (p_undef) else $error("undefined trap sequence wrong");

  property p_busy_count;
    state_ff == ST_WAIT |=> busy_count_ff == $past(busy_count_ff) + 16'h0001;
  endproperty
  a_busy_count: assert property (p_busy_count) else $error("busy cycle not counted");
endmodule : coproc_register_transfer

// File: coproc_model.sv
// Purpose: Attached coprocessor model facing the register transfer block
// Assumes: Handshake is sampled by the core in offer and wait cycles
// Notes: Refuses when not selected or when told to
`timescale 1ns/1ps
module coproc_model
  import coproc_xfer_pkg::*;
#(
  parameter logic [3:0] NUM = 4'h5
)(
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic offer_ff,
  input wire logic dir_load_ff,
  input wire logic [2:0] cycle_kind_ff,
  input wire logic [3:0] coproc_number_field_ff,
  input wire logic [3:0] busy_len,
  input wire logic refuse,
  input wire logic [31:0] word,
  output logic coproc_absent_signal,
  output logic coproc_wait_signal,
  output logic [31:0] coproc_rdata
);
  logic [3:0] cnt_ff;
  logic [3:0] nxt_cnt;
  logic sel;
  ////////////////////////////////////////////////////////////////////////////////
  always_comb begin
    sel = (coproc_number_field_ff == NUM);
    nxt_cnt = offer_ff ? cnt_ff + 4'h1 : 4'h0;
    coproc_absent_signal = offer_ff & (~sel | refuse);
    coproc_wait_signal = offer_ff & (~sel | refuse | (cnt_ff < busy_len));
    coproc_rdata = (sel && dir_load_ff && cycle_kind_ff == CYC_COPROC) ? word : ~word;
  end
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      cnt_ff <= 4'h0;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end
endmodule : coproc_model

// File: coproc_register_transfer_bench.sv
// Purpose: Self-checking bench for the coprocessor register transfer block
// Assumes: Inputs driven at the falling edge, clock enable held high except during the frozen check
// Notes: Table rows first, then held request and mid-run reset
`timescale 1ns/1ps
module coproc_register_transfer_bench;
  import coproc_xfer_pkg::*;
  typedef struct {
    logic [31:0] ins;
    logic [31:0] adr;
    logic [31:0] core;
    logic [31:0] wd;
    logic [3:0] flg;
    logic [3:0] b;
    logic rf;
    logic [15:0] sinc;
    logic [3:0] ev;
  } row_s;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic clk_en = 1'b1;
  logic instr_valid = 1'b0;
  logic refuse = 1'b0;
  logic [31:0] instr = 32'h0, instr_addr = 32'h0, core_rdata = 32'h0, word = 32'h0;
  logic [3:0] flags_in = 4'h0, busy_len = 4'h0;
  logic coproc_absent_signal, coproc_wait_signal, busy_ff, done_ff, offer_ff, dir_load_ff;
  logic coproc_wdata_valid_ff, reg_we_ff, flag_we_ff, undef_trap_ff;
  logic [31:0] coproc_rdata, coproc_wdata_ff, reg_wdata_ff;
  logic [3:0] coproc_number_field_ff, coproc_primary_register_ff, coproc_second_operand_reg_ff;
  logic [3:0] reg_idx_ff, flag_data_ff;
  logic [2:0] coproc_opcode_field_ff, coproc_info_field_ff, cycle_kind_ff;
  logic [15:0] busy_count_ff;
  logic [9:0] mem_offset_ff;
  logic [3:0] kinds [0:4];
  row_s rows [0:10];
  int error_cnt = 0;
  int cmp_count = 0;
  ////////////////////////////////////////////////////////////////////////////////
  always #20 sys_clk = ~sys_clk;
  coproc_register_transfer dut (.sys_clk(sys_clk), .resetn(resetn), .clk_en(clk_en), .instr_valid(instr_valid),
    .instr(instr), .instr_addr(instr_addr), .core_rdata(core_rdata), .flags_in(flags_in),
    .coproc_absent_signal(coproc_absent_signal), .coproc_wait_signal(coproc_wait_signal),
    .coproc_rdata(coproc_rdata), .busy_ff(busy_ff), .done_ff(done_ff), .offer_ff(offer_ff),
    .dir_load_ff(dir_load_ff), .coproc_number_field_ff(coproc_number_field_ff),
    .coproc_opcode_field_ff(coproc_opcode_field_ff), .coproc_info_field_ff(coproc_info_field_ff),
    .coproc_primary_register_ff(coproc_primary_register_ff),
    .coproc_second_operand_reg_ff(coproc_second_operand_reg_ff), .coproc_wdata_ff(coproc_wdata_ff),
    .coproc_wdata_valid_ff(coproc_wdata_valid_ff), .reg_we_ff(reg_we_ff), .reg_idx_ff(reg_idx_ff),
    .reg_wdata_ff(reg_wdata_ff), .flag_we_ff(flag_we_ff), .flag_data_ff(flag_data_ff),
    .undef_trap_ff(undef_trap_ff), .cycle_kind_ff(cycle_kind_ff), .busy_count_ff(busy_count_ff),
    .mem_offset_ff(mem_offset_ff));
  coproc_model #(.NUM(4'h5)) partner (.sys_clk(sys_clk), .resetn(resetn), .offer_ff(offer_ff),
    .dir_load_ff(dir_load_ff), .cycle_kind_ff(cycle_kind_ff), .coproc_number_field_ff(coproc_number_field_ff),
    .busy_len(busy_len), .refuse(refuse), .word(word), .coproc_absent_signal(coproc_absent_signal),
    .coproc_wait_signal(coproc_wait_signal), .coproc_rdata(coproc_rdata));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check
  task automatic close_out();
    $display("Compares %0d, mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : close_out
  task automatic start(input int i, input logic hold);
    @(negedge sys_clk);
    instr = rows[i].ins;
    instr_addr = rows[i].adr;
    core_rdata = rows[i].core;
    flags_in = rows[i].flg;
    busy_len = rows[i].b;
    refuse = rows[i].rf;
    word = rows[i].wd;
    instr_valid = 1'b1;
    @(negedge sys_clk);
    instr_valid = hold;
    if (hold) instr = 32'he6000010;
    for (int k = 0; k < 5; k++) kinds[k] = 4'h0;
  endtask : start
  task automatic finish(input int i);
    int k;
    logic [31:0] ins;
    logic [31:0] exp_w;
    k = 0;
    ins = rows[i].ins;
    while (done_ff !== 1'b1 && k < 40) begin
      if (k == 2) instr_valid = 1'b0;
      kinds[cycle_kind_ff] = kinds[cycle_kind_ff] + 4'h1;
      @(negedge sys_clk);
      k++;
    end
    check({31'h0, (k < 40)}, 32'h1, "completion");
    if (k == 40) begin
      close_out();
    end else begin
      check({16'h0, kinds[1], kinds[3], kinds[2], kinds[4]}, {16'h0, rows[i].sinc},
        "cycle mix");
      check({28'h0, reg_we_ff, flag_we_ff, undef_trap_ff, coproc_wdata_valid_ff}, {28'h0, rows[i].ev},
        "events");
      exp_w = (ins[15:12] == PC_INDEX) ? rows[i].adr + PC_AHEAD : rows[i].core;
      if (rows[i].ev[0]) check(coproc_wdata_ff, exp_w, "word out");
      if (rows[i].ev[3]) check(reg_wdata_ff, rows[i].wd, "core data");
      if (rows[i].ev[3]) check({28'h0, reg_idx_ff}, {28'h0, ins[15:12]}, "core index");
      if (rows[i].ev[2]) check({28'h0, flag_data_ff}, {28'h0, rows[i].wd[31:28]}, "flags");
      if (rows[i].sinc[3:0] == 4'h1) begin
        check({13'h0, coproc_number_field_ff, coproc_opcode_field_ff, coproc_info_field_ff,
          coproc_primary_register_ff, coproc_second_operand_reg_ff, dir_load_ff},
          {13'h0, ins[11:8], ins[23:21], ins[7:5], ins[19:16], ins[3:0], ins[20]},
          "fields");
        check({16'h0, busy_count_ff}, {28'h0, rows[i].b}, "busy count");
      end
      check({31'h0, busy_ff}, 32'h0, "idle");
      $display("Test row %0d done", i);
    end
  endtask : finish
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    rows[0] = '{32'hee434536, 32'h100, 32'h11223344, 32'h0, 4'h0, 4'h0, 1'b0, 16'h1001, 4'h1};
    rows[1] = '{32'hee43f536, 32'h200, 32'h55, 32'h0, 4'h0, 4'h3, 1'b0, 16'h1301, 4'h1};
    rows[2] = '{32'hee534536, 32'h0, 32'h0, 32'h12345678, 4'h0, 4'h0, 1'b0, 16'h1101, 4'h8};
    rows[3] = '{32'hee53f536, 32'h0, 32'h0, 32'ha5000000, 4'h0, 4'h2, 1'b0, 16'h1301, 4'h4};
    rows[4] = '{32'h0e534536, 32'h0, 32'h0, 32'h1, 4'h0, 4'h0, 1'b0, 16'h0, 4'h0};
    rows[5] = '{32'hfe434536, 32'h0, 32'h0, 32'h0, 4'hf, 4'h0, 1'b0, 16'h0, 4'h0};
    rows[6] = '{32'h0e434536, 32'h40, 32'h9, 32'h0, 4'h4, 4'h1, 1'b0, 16'h1101, 4'h1};
    rows[7] = '{32'he6000010, 32'h0, 32'h0, 32'h0, 4'h0, 4'h0, 1'b1, 16'h2110, 4'h2};
    rows[8] = '{32'hee434336, 32'h0, 32'h0, 32'h0, 4'h0, 4'h0, 1'b0, 16'h2110, 4'h2};
    rows[9] = '{32'he1a00000, 32'h0, 32'h0, 32'h0, 4'h0, 4'h0, 1'b0, 16'h0, 4'h0};
    rows[10] = '{32'hec000007, 32'h0, 32'h0, 32'h0, 4'h0, 4'h0, 1'b0, 16'h0, 4'h0};
    repeat (3) @(negedge sys_clk);
    check({29'h0, busy_ff, done_ff, undef_trap_ff}, 32'h0, "reset outputs");
    check({29'h0, cycle_kind_ff}, 32'h0, "reset kind");
    resetn = 1'b1;
    $display("Test reset done");
    for (int i = 0; i < 11; i++) begin
      start(i, 1'b0);
      finish(i);
    end
    check({22'h0, mem_offset_ff}, {22'h0, rows[10].ins[7:0], 2'b00}, "word offset");
    start(1, 1'b1);
    finish(1);
    start(3, 1'b0);
    @(negedge sys_clk);
    resetn = 1'b0;
    @(negedge sys_clk);
    check({29'h0, busy_ff, flag_we_ff, offer_ff}, 32'h0, "mid reset");
    resetn = 1'b1;
    $display("Test mid reset done");
    @(negedge sys_clk);
    clk_en = 1'b0;
    instr = rows[0].ins;
    flags_in = 4'h0;
    instr_valid = 1'b1;
    repeat (2) @(negedge sys_clk);
    check({29'h0, busy_ff, done_ff, offer_ff}, 32'h0, "frozen");
    clk_en = 1'b1;
    instr_valid = 1'b0;
    $display("Test clock enable done");
    start(3, 1'b0);
    finish(3);
    close_out();
  end
endmodule : coproc_register_transfer_bench
